// ===== rtl/hcr_map.svh
// Register offsets, status bit positions and reset values of the handshake block
`ifndef HCR_MAP_SVH
`define HCR_MAP_SVH

`define HCR_ADDR_W      3
`define HCR_OFS_STATUS  3'h0
`define HCR_OFS_COMMAND 3'h0
`define HCR_OFS_PARAM   3'h1
`define HCR_OFS_IMM     3'h2
`define HCR_OFS_RXRES   3'h3
`define HCR_OFS_TXRES   3'h4
`define HCR_OFS_MODE    3'h5
`define HCR_OFS_RXDATA  3'h6
`define HCR_OFS_TXDATA  3'h7

`define HCR_ST_ACTIVE   7
`define HCR_ST_CMD      6
`define HCR_ST_PAR      5
`define HCR_ST_IMM      4
`define HCR_ST_RXSR     3
`define HCR_ST_TXSR     2
`define HCR_ST_RXRDY    1
`define HCR_ST_TXRDY    0

`define HCR_MODE_INTX   0
`define HCR_MODE_RST    8'h00
`define HCR_BYTE_RST    8'h00

`endif

// ===== rtl/hcr_pkg.sv
// Types shared by the host command and result handshake block
package hcr_pkg;

    typedef enum logic {
        HCR_PH_IDLE,
        HCR_PH_CMD
    } hcr_phase_t;

    // One result byte offered by the internal processor for one direction
    typedef struct packed {
        logic       load;
        logic       busy;
        logic [7:0] data;
    } hcr_res_t;

    // Command phase events from the internal processor
    typedef struct packed {
        logic cmd_take;
        logic cmd_nopar;
        logic par_take;
        logic par_last;
    } hcr_take_t;

endpackage

// ===== rtl/hcr_flag.sv
// Sticky handshake flag where a set in the clear cycle wins
module hcr_flag
(
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      q_o
);

    logic next_q;

    assign next_q = set_i | (q_o & ~clr_i);

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            q_o <= 1'b0;
        else
            q_o <= next_q;
    end

    chk_set_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        set_i |=> q_o)
        else $error("flag lost a set");
    chk_clear_acts: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clr_i && !set_i |=> !q_o)
        else $error("flag not cleared");

endmodule

// ===== rtl/hcr_chan.sv
// One direction: result byte, result-ready flag, service request, data request
`include "hcr_map.svh"

module hcr_chan
    import hcr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       int_mode_i,
    input  wire hcr_res_t   res_i,
    input  wire logic       res_read_i,
    input  wire logic       xfer_req_i,
    input  wire logic       host_xfer_i,
    input  wire logic       dma_ack_i,
    output logic [7:0]      res_data_o,
    output logic            ready_o,
    output logic            service_o,
    output logic            dma_req_o
);

    logic pending;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            res_data_o <= `HCR_BYTE_RST;
        else if (res_i.load)
            res_data_o <= res_i.data;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ready_o <= 1'b0;
        else
            ready_o <= res_i.load | (ready_o & ~res_read_i);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pending <= 1'b0;
        else
            pending <= xfer_req_i | (pending & ~(host_xfer_i | dma_ack_i));
    end

    // Busy keeps the request up until the last result byte is read
    assign service_o = ready_o | res_i.busy | (pending & int_mode_i);
    assign dma_req_o = pending & ~int_mode_i;

endmodule

// ===== rtl/hcr_handshake.sv
// Host command, parameter and result handshake of a serial link controller
//
// Notes on behaviour
// - Command write starts the command phase
// - Last accepted parameter ends the command phase
// - Command held until internal processor takes it
// - Parameter held until internal logic accepts it
// - Immediate result held until host reads it
// - Receive request pin equals status bit
// - Transmit request behaves like receive request
// - Receive result ready until host reads it
// - Transmit result ready until host reads it
// - Both directions run and report concurrently
// - Ready flag tells transfer from completion
// - DMA mode moves data without host accesses
// - Success or error both enter result phase
// - Immediate results only in immediate register
//
// Added by the designer: the placing of the registers and strobed register access.
`include "hcr_map.svh"

module hcr_handshake
    import hcr_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    // Register port
    input  wire logic [`HCR_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic [7:0]                  rdata_o,
    // Internal processor, command side
    input  wire hcr_take_t              take_i,
    output logic [7:0]                  cmd_byte_o,
    output logic                        cmd_held_o,
    output logic [7:0]                  par_byte_o,
    output logic                        par_held_o,
    input  wire logic                   imm_load_i,
    input  wire logic [7:0]             imm_data_i,
    // Internal processor, receive direction
    input  wire hcr_res_t               rx_res_i,
    input  wire logic                   rx_xfer_req_i,
    input  wire logic [7:0]             rx_xfer_data_i,
    input  wire logic                   rx_dma_ack_i,
    output logic                        rx_dma_req_o,
    output logic                        rx_service_o,
    // Internal processor, transmit direction
    input  wire hcr_res_t               tx_res_i,
    input  wire logic                   tx_xfer_req_i,
    input  wire logic                   tx_dma_ack_i,
    output logic                        tx_dma_req_o,
    output logic                        tx_service_o,
    output logic [7:0]                  tx_data_o,
    output logic                        tx_data_stb_o,
    output logic                        int_mode_o
);

    //**************************************************************
    // Decode
    //**************************************************************
    logic       wr_cmd;
    logic       wr_par;
    logic       wr_mode;
    logic       wr_txd;
    logic       rd_imm;
    logic       rd_rxres;
    logic       rd_txres;
    logic       rd_rxd;
    logic       phase_end;
    logic       imm_held;
    logic       rx_ready;
    logic       tx_ready;
    logic [7:0] imm_data;
    logic [7:0] rx_res_data;
    logic [7:0] tx_res_data;
    logic [7:0] mode;
    logic [7:0] status;
    logic [7:0] next_rdata;
    hcr_phase_t phase;

    assign wr_cmd   = wr_i && (addr_i == `HCR_OFS_COMMAND);
    assign wr_par   = wr_i && (addr_i == `HCR_OFS_PARAM);
    assign wr_mode  = wr_i && (addr_i == `HCR_OFS_MODE);
    assign wr_txd   = wr_i && (addr_i == `HCR_OFS_TXDATA);
    assign rd_imm   = rd_i && (addr_i == `HCR_OFS_IMM);
    assign rd_rxres = rd_i && (addr_i == `HCR_OFS_RXRES);
    assign rd_txres = rd_i && (addr_i == `HCR_OFS_TXRES);
    assign rd_rxd   = rd_i && (addr_i == `HCR_OFS_RXDATA);

    //**************************************************************
    // Command phase
    //**************************************************************
    // A parameterless command ends the phase when it is taken
    assign phase_end = (take_i.par_take && take_i.par_last)
                     || (take_i.cmd_take && take_i.cmd_nopar);

    // A new command in the ending cycle keeps the phase open
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            phase <= HCR_PH_IDLE;
        else if (wr_cmd)
            phase <= HCR_PH_CMD;
        else if (phase_end)
            phase <= HCR_PH_IDLE;
    end

    // A second command write simply overwrites; the host must avoid it
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cmd_byte_o <= `HCR_BYTE_RST;
        else if (wr_cmd)
            cmd_byte_o <= wdata_i;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            par_byte_o <= `HCR_BYTE_RST;
        else if (wr_par)
            par_byte_o <= wdata_i;
    end

    hcr_flag u_cmd_flag
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .set_i     (wr_cmd),
        .clr_i     (take_i.cmd_take),
        .q_o       (cmd_held_o)
    );

    hcr_flag u_par_flag
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .set_i     (wr_par),
        .clr_i     (take_i.par_take),
        .q_o       (par_held_o)
    );

    //**************************************************************
    // Immediate result
    //**************************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            imm_data <= `HCR_BYTE_RST;
        else if (imm_load_i)
            imm_data <= imm_data_i;
    end

    hcr_flag u_imm_flag
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .set_i     (imm_load_i),
        .clr_i     (rd_imm),
        .q_o       (imm_held)
    );

    //**************************************************************
    // Mode and data transfer
    //**************************************************************
    // Mode bit clear selects DMA requests, set selects interrupts
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            mode <= `HCR_MODE_RST;
        else if (wr_mode)
            mode <= wdata_i;
    end

    assign int_mode_o = mode[`HCR_MODE_INTX];

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            tx_data_o <= `HCR_BYTE_RST;
        else if (wr_txd)
            tx_data_o <= wdata_i;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            tx_data_stb_o <= 1'b0;
        else
            tx_data_stb_o <= wr_txd;
    end

    //**************************************************************
    // Receive and transmit channels
    //**************************************************************
    // Two independent channels so both directions report at once
    hcr_chan u_rx_chan
    (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .int_mode_i  (int_mode_o),
        .res_i       (rx_res_i),
        .res_read_i  (rd_rxres),
        .xfer_req_i  (rx_xfer_req_i),
        .host_xfer_i (rd_rxd),
        .dma_ack_i   (rx_dma_ack_i),
        .res_data_o  (rx_res_data),
        .ready_o     (rx_ready),
        .service_o   (rx_service_o),
        .dma_req_o   (rx_dma_req_o)
    );

    hcr_chan u_tx_chan
    (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .int_mode_i  (int_mode_o),
        .res_i       (tx_res_i),
        .res_read_i  (rd_txres),
        .xfer_req_i  (tx_xfer_req_i),
        .host_xfer_i (wr_txd),
        .dma_ack_i   (tx_dma_ack_i),
        .res_data_o  (tx_res_data),
        .ready_o     (tx_ready),
        .service_o   (tx_service_o),
        .dma_req_o   (tx_dma_req_o)
    );

    //**************************************************************
    // Status and read data
    //**************************************************************
    always_comb
    begin
        status                = 8'h00;
        status[`HCR_ST_ACTIVE] = (phase == HCR_PH_CMD);
        status[`HCR_ST_CMD]   = cmd_held_o;
        status[`HCR_ST_PAR]   = par_held_o;
        status[`HCR_ST_IMM]   = imm_held;
        status[`HCR_ST_RXSR]  = rx_service_o;
        status[`HCR_ST_TXSR]  = tx_service_o;
        status[`HCR_ST_RXRDY] = rx_ready;
        status[`HCR_ST_TXRDY] = tx_ready;
    end

    always_comb
    begin
        next_rdata = 8'h00;
        unique case (addr_i)
            `HCR_OFS_STATUS: next_rdata = status;
            `HCR_OFS_IMM:    next_rdata = imm_data;
            `HCR_OFS_RXRES:  next_rdata = rx_res_data;
            `HCR_OFS_TXRES:  next_rdata = tx_res_data;
            `HCR_OFS_MODE:   next_rdata = mode;
            `HCR_OFS_RXDATA: next_rdata = rx_xfer_data_i;
            default:         next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= next_rdata;
        else
            rdata_o <= 8'h00;
    end

    //**************************************************************
    // Checks
    //**************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_cmd_starts: assert property (
        wr_cmd |=> status[`HCR_ST_ACTIVE] && cmd_held_o)
        else $error("command write did not open phase");
    chk_phase_ends: assert property (
        phase_end && !wr_cmd |=> !status[`HCR_ST_ACTIVE])
        else $error("phase not closed after last parameter");
    chk_cmd_taken: assert property (
        take_i.cmd_take && !wr_cmd |=> !cmd_held_o)
        else $error("command flag stuck after take");
    chk_par_held: assert property (
        wr_par |=> par_held_o && (par_byte_o == $past(wdata_i)))
        else $error("parameter not held");
    chk_imm_result: assert property (
        rd_imm && !imm_load_i |=> !imm_held && rdata_o == $past(imm_data))
        else $error("immediate result handshake wrong");
    chk_rx_pin: assert property (
        rd_i && addr_i == `HCR_OFS_STATUS
        |=> rdata_o[`HCR_ST_RXSR] == $past(rx_service_o)
            && rdata_o[`HCR_ST_TXSR] == $past(tx_service_o))
        else $error("request bit differs from pin");
    chk_rx_ready: assert property (
        rx_res_i.load |=> rx_ready && rx_service_o)
        else $error("receive result not flagged");
    chk_tx_ready: assert property (
        rd_txres && !tx_res_i.load |=> !tx_ready && rdata_o == $past(tx_res_data))
        else $error("transmit ready not cleared");
    chk_dma_quiet: assert property (
        !int_mode_o && tx_xfer_req_i && !wr_mode
        |=> tx_dma_req_o && !(tx_service_o && !tx_ready && !tx_res_i.busy))
        else $error("DMA transfer raised service request");
    chk_reset_clear: assert property (
        $fell(sys_rst_i) |-> status == 8'h00 && !rx_dma_req_o && !tx_dma_req_o)
        else $error("flags not clear after reset");
    chk_phase_stays: assert property (
        status[`HCR_ST_ACTIVE] && !phase_end |=> status[`HCR_ST_ACTIVE])
        else $error("command phase closed early");
    chk_par_taken: assert property (
        take_i.par_take && !wr_par |=> !par_held_o)
        else $error("parameter flag stuck after take");
    chk_rx_result: assert property (
        rd_rxres && !rx_res_i.load |=> !rx_ready && rdata_o == $past(rx_res_data))
        else $error("receive result read wrong");
    chk_tx_loaded: assert property (
        tx_res_i.load |=> tx_ready && tx_service_o)
        else $error("transmit result not flagged");
    chk_both_report: assert property (
        rx_res_i.load && tx_res_i.load |=> rx_ready && tx_ready
            && rx_res_data == $past(rx_res_i.data) && tx_res_data == $past(tx_res_i.data))
        else $error("directions did not report together");
    chk_xfer_request: assert property (
        int_mode_o && rx_xfer_req_i && !wr_mode |=> rx_service_o && !rx_dma_req_o)
        else $error("transfer request not raised");
    chk_xfer_done: assert property (
        rd_rxd && !rx_xfer_req_i |=> !rx_dma_req_o && rx_service_o == (rx_ready || rx_res_i.busy))
        else $error("request kept after data transfer");
    chk_dma_ack: assert property (
        tx_dma_ack_i && !tx_xfer_req_i |=> !tx_dma_req_o)
        else $error("DMA request kept after acknowledge");
    chk_mode_select: assert property (
        wr_mode |=> int_mode_o == $past(wdata_i[`HCR_MODE_INTX]))
        else $error("transfer mode not taken");
    chk_imm_only: assert property (
        !imm_load_i |=> imm_data == $past(imm_data))
        else $error("immediate result changed without load");

endmodule

// ===== tb/hcr_host_model.sv
// Host processor model that drives the register port of the handshake block
`include "hcr_map.svh"

module hcr_host_model
(
    input  wire logic       clk_i,
    output logic [2:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    input  wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        addr_o  = 3'h0;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // ************************************************************
    // Bus cycles
    // ************************************************************
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        // Released data is scrambled so a stale byte never looks valid
        wdata_o <= ~d;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        #1;
        d = rdata_i;
    endtask

    // Bounded poll; a flag that never settles returns ok low
    task automatic poll(input int bit_no, input logic want, output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 16 && !ok; i++)
        begin
            rd(`HCR_OFS_STATUS, s);
            ok = (s[bit_no] === want);
        end
    endtask

    task automatic issue_cmd(input logic [7:0] c, output logic ok);
        poll(`HCR_ST_ACTIVE, 1'b0, ok);
        wr(`HCR_OFS_COMMAND, c);
    endtask

    task automatic put_par(input logic [7:0] p, output logic ok);
        poll(`HCR_ST_PAR, 1'b0, ok);
        wr(`HCR_OFS_PARAM, p);
    endtask

    task automatic get_imm(output logic [7:0] d, output logic ok);
        poll(`HCR_ST_IMM, 1'b1, ok);
        rd(`HCR_OFS_IMM, d);
    endtask

    task automatic get_res(input logic tx, output logic [7:0] d, output logic ok);
        logic [7:0] s;
        rd(`HCR_OFS_STATUS, s);
        // Request with ready set is a completion and sets ok; the result is read either way
        ok = s[tx ? `HCR_ST_TXSR : `HCR_ST_RXSR];
        ok = ok & s[tx ? `HCR_ST_TXRDY : `HCR_ST_RXRDY];
        rd(tx ? `HCR_OFS_TXRES : `HCR_OFS_RXRES, d);
    endtask
endmodule

// ===== tb/tb_hcr_handshake.sv
// Self-checking bench for the host command and result handshake block
`include "hcr_map.svh"

module tb_hcr_handshake
    import hcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] s_act = 8'h01 << `HCR_ST_ACTIVE;
    localparam logic [7:0] s_cmd = 8'h01 << `HCR_ST_CMD;
    localparam logic [7:0] s_par = 8'h01 << `HCR_ST_PAR;
    localparam logic [7:0] s_imm = 8'h01 << `HCR_ST_IMM;
    localparam logic [7:0] s_rxsr = 8'h01 << `HCR_ST_RXSR;
    localparam logic [7:0] s_txsr = 8'h01 << `HCR_ST_TXSR;
    localparam logic [7:0] s_rxrdy = 8'h01 << `HCR_ST_RXRDY;
    localparam logic [7:0] s_txrdy = 8'h01 << `HCR_ST_TXRDY;

    logic       clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, cmd_byte, par_byte, tx_data, rd_val;
    logic       wr, rd, cmd_held, par_held, rx_dma_req, rx_service, ok;
    logic       tx_dma_req, tx_service, tx_data_stb, int_mode;
    hcr_take_t  take = '0;
    hcr_res_t   rx_res = '0;
    hcr_res_t   tx_res = '0;
    logic [4:0] ev = '0; // {tx_dma_ack, rx_dma_ack, tx_xfer_req, rx_xfer_req, imm_load}
    logic [7:0] imm_data = 8'h00;
    logic [7:0] rx_xfer_data = 8'h00;
    int         error_cnt = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         stb_cnt = 0;

    always #2.5 clk_i = ~clk_i;

    hcr_handshake dut_u
    (
        .clk_i          (clk_i),
        .sys_rst_i      (sys_rst_i),
        .addr_i         (addr),
        .wdata_i        (wdata),
        .wr_i           (wr),
        .rd_i           (rd),
        .rdata_o        (rdata),
        .take_i         (take),
        .cmd_byte_o     (cmd_byte),
        .cmd_held_o     (cmd_held),
        .par_byte_o     (par_byte),
        .par_held_o     (par_held),
        .imm_load_i     (ev[0]),
        .imm_data_i     (imm_data),
        .rx_res_i       (rx_res),
        .rx_xfer_req_i  (ev[1]),
        .rx_xfer_data_i (rx_xfer_data),
        .rx_dma_ack_i   (ev[3]),
        .rx_dma_req_o   (rx_dma_req),
        .rx_service_o   (rx_service),
        .tx_res_i       (tx_res),
        .tx_xfer_req_i  (ev[2]),
        .tx_dma_ack_i   (ev[4]),
        .tx_dma_req_o   (tx_dma_req),
        .tx_service_o   (tx_service),
        .tx_data_o      (tx_data),
        .tx_data_stb_o  (tx_data_stb),
        .int_mode_o     (int_mode)
    );

    hcr_host_model host_u
    (
        .clk_i   (clk_i),
        .addr_o  (addr),
        .wdata_o (wdata),
        .wr_o    (wr),
        .rd_o    (rd),
        .rdata_i (rdata)
    );

    // Cycle ceiling well above the couple of hundred cycles the run needs
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (tx_data_stb === 1'b1)
            stb_cnt <= stb_cnt + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            summarize();
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic summarize();
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdreg(input logic [2:0] a, input logic [7:0] exp);
        host_u.rd(a, rd_val);
        chk(rd_val, exp);
    endtask

    task automatic fire(input logic [4:0] e, input hcr_take_t t, input logic [7:0] d);
        @(posedge clk_i);
        ev           <= e;
        take         <= t;
        imm_data     <= d;
        rx_xfer_data <= d;
        @(posedge clk_i);
        ev           <= '0;
        take         <= '0;
        #1;
    endtask

    task automatic load(input logic [1:0] which, input logic busy, input logic [7:0] d);
        @(posedge clk_i);
        if (which[0])
            rx_res <= '{1'b1, busy, d};
        if (which[1])
            tx_res <= '{1'b1, busy, d};
        @(posedge clk_i);
        rx_res.load <= 1'b0;
        tx_res.load <= 1'b0;
        #1;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        rdreg(`HCR_OFS_STATUS, 8'h00);
        chk({rx_service, tx_service, rx_dma_req, tx_dma_req, cmd_held, par_held,
             int_mode, 1'b0}, 8'h00);
        rdreg(`HCR_OFS_MODE, `HCR_MODE_RST);
        host_u.wr(`HCR_OFS_RXRES, 8'hff);
        host_u.wr(`HCR_OFS_IMM, 8'hff);
        rdreg(3'h7, 8'h00);
        rdreg(`HCR_OFS_IMM, `HCR_BYTE_RST);
        rdreg(`HCR_OFS_STATUS, 8'h00);
    endtask

    task automatic t_cmd();
        host_u.issue_cmd(8'hc3, ok);
        chk(cmd_byte, 8'hc3);
        rdreg(`HCR_OFS_STATUS, s_act | s_cmd);
        fire('0, 4'h8, 8'h00);
        rdreg(`HCR_OFS_STATUS, s_act);
        host_u.put_par(8'h11, ok);
        rdreg(`HCR_OFS_STATUS, s_act | s_par);
        host_u.wr(`HCR_OFS_PARAM, 8'h22);
        chk(par_byte, 8'h22);
        fire('0, 4'h2, 8'h00);
        rdreg(`HCR_OFS_STATUS, s_act);
        host_u.put_par(8'h33, ok);
        chk({7'h0, ok}, 8'h01);
        fire('0, 4'h3, 8'h00);
        rdreg(`HCR_OFS_STATUS, 8'h00);
        host_u.issue_cmd(8'h5c, ok);
        fire('0, 4'hc, 8'h00);
        rdreg(`HCR_OFS_STATUS, 8'h00);
    endtask

    task automatic t_imm();
        host_u.issue_cmd(8'h21, ok);
        fire(5'h01, 4'hc, 8'ha5);
        rdreg(`HCR_OFS_STATUS, s_imm);
        host_u.get_imm(rd_val, ok);
        chk({7'h0, ok}, 8'h01);
        chk(rd_val, 8'ha5);
        rdreg(`HCR_OFS_STATUS, 8'h00);
        rdreg(`HCR_OFS_RXRES, 8'h00);
    endtask

    task automatic t_result();
        load(2'h3, 1'b1, 8'h81);
        rdreg(`HCR_OFS_STATUS, s_rxsr | s_txsr | s_rxrdy | s_txrdy);
        chk({6'h0, rx_service, tx_service}, 8'h03);
        host_u.get_res(1'b0, rd_val, ok);
        chk({7'h0, ok}, 8'h01);
        chk(rd_val, 8'h81);
        rdreg(`HCR_OFS_STATUS, s_rxsr | s_txsr | s_txrdy);
        host_u.get_res(1'b1, rd_val, ok);
        chk(rd_val, 8'h81);
        rdreg(`HCR_OFS_STATUS, s_rxsr | s_txsr);
        load(2'h3, 1'b0, 8'h82);
        host_u.get_res(1'b0, rd_val, ok);
        chk(rd_val, 8'h82);
        host_u.get_res(1'b1, rd_val, ok);
        chk(rd_val, 8'h82);
        chk({6'h0, rx_service, tx_service}, 8'h00);
        rdreg(`HCR_OFS_STATUS, 8'h00);
    endtask

    task automatic t_xfer();
        host_u.wr(`HCR_OFS_MODE, 8'h01);
        rdreg(`HCR_OFS_MODE, 8'h01);
        fire(5'h02, '0, 8'h96);
        rdreg(`HCR_OFS_STATUS, s_rxsr);
        rdreg(`HCR_OFS_RXDATA, 8'h96);
        rdreg(`HCR_OFS_STATUS, 8'h00);
        fire(5'h04, '0, 8'h00);
        rdreg(`HCR_OFS_STATUS, s_txsr);
        host_u.wr(`HCR_OFS_TXDATA, 8'h3c);
        repeat (2) @(posedge clk_i);
        #1;
        chk(tx_data, 8'h3c);
        chk(stb_cnt[7:0], 8'h01);
        rdreg(`HCR_OFS_STATUS, 8'h00);
    endtask

    task automatic t_dma();
        host_u.wr(`HCR_OFS_MODE, 8'h00);
        fire(5'h06, '0, 8'h00);
        chk({4'h0, rx_dma_req, tx_dma_req, rx_service, tx_service}, 8'h0c);
        fire(5'h18, '0, 8'h00);
        chk({4'h0, rx_dma_req, tx_dma_req, rx_service, tx_service}, 8'h00);
    endtask

    task automatic t_midreset();
        host_u.wr(`HCR_OFS_MODE, 8'h01);
        host_u.issue_cmd(8'h42, ok);
        load(2'h3, 1'b1, 8'h90);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        rx_res    <= '0;
        tx_res    <= '0;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        t_reset();
    endtask

    initial
    begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        t_reset();
        t_cmd();
        t_imm();
        t_result();
        t_xfer();
        t_dma();
        t_midreset();
        summarize();
    end
endmodule
